// >>> hdl/counter_regs_pkg.sv
// Register map, field positions and state encodings of the counter capture block
package counter_regs_pkg;

    localparam logic [7:0] BANK_PTR_ADDR       = 8'hfd;
    localparam logic [7:0] BANK_PTR_RESET      = 8'h00;
    localparam logic [3:0] BANK_NORMAL         = 4'h0;
    localparam logic [3:0] BANK_CTRL_D         = 4'hd;
    localparam logic [3:0] BANK_CTRL_F         = 4'hf;
    localparam logic [3:0] LOW_GROUP           = 4'h0;

    localparam logic [3:0] WIDE_CTRL_OFS       = 4'h2;
    localparam logic [3:0] SHARED_CTRL_OFS     = 4'h3;
    localparam logic [3:0] WIDE_HOLD_LOWER_OFS = 4'h6;
    localparam logic [3:0] WIDE_HOLD_UPPER_OFS = 4'h7;
    localparam logic [3:0] WIDE_CAP_LOWER_OFS  = 4'h8;
    localparam logic [3:0] WIDE_CAP_UPPER_OFS  = 4'h9;
    localparam logic [3:0] NARROW_CAP_LOW_OFS  = 4'ha;
    localparam logic [3:0] NARROW_CAP_HIGH_OFS = 4'hb;

    localparam int SH_WIDE_RUN_BIT   = 7;
    localparam int SH_NARROW_RUN_BIT = 6;
    localparam int SH_SYNC_BIT       = 5;

    localparam int WC_PIN_SEL_BIT   = 0;
    localparam int WC_CNT_MASK_BIT  = 1;
    localparam int WC_CAP_MASK_BIT  = 2;
    localparam int WC_RATE_BIT      = 3;
    localparam int WC_TIMEOUT_BIT   = 4;
    localparam int WC_EDGE_ONCE_BIT = 5;
    localparam int WC_DEMOD_BIT     = 6;

    localparam logic [7:0] WIDE_CTRL_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET      = 8'h00;
    localparam logic [7:0] CAPTURE_RESET   = 8'h00;
    localparam logic [7:0] NARROW_MAX      = 8'hff;
    localparam int         WIDE_RATE_DIV   = 8;

    typedef enum logic [1:0] {
        WS_STOP = 2'b00,
        WS_RUN  = 2'b01,
        WS_HELD = 2'b10
    } wide_state_t;

endpackage : counter_regs_pkg

// >>> hdl/edge_if.sv
// Synchronised input level and edge strobes passed to the counter logic
`timescale 1ns/10ps
interface edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src  (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface : edge_if

// >>> hdl/edge_sync.sv
// Two-stage synchroniser and edge detector for the demodulation input pin
`timescale 1ns/10ps
module edge_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_in,
    edge_if.src       ev
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic last_q, last_d;

    always_comb
    begin
        meta_d = pin_in;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // Edges seen only past the second stage
    assign ev.level = sync_q;
    assign ev.rise  = sync_q & ~last_q;
    assign ev.fall  = ~sync_q & last_q;

endmodule : edge_sync

// >>> hdl/dual_counter_capture_regs.sv
// Capture, hold and control registers of the narrow and wide counters
`timescale 1ns/10ps
module dual_counter_capture_regs #(
    parameter int RATE_DIV = counter_regs_pkg::WIDE_RATE_DIV
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    output logic      [3:0] bank_group,
    input  wire logic       demod_in,
    input  wire logic       gpo_value,
    output logic            pin_out,
    output logic            irq_capture,
    output logic            irq_timeout
);
    import counter_regs_pkg::*;

    edge_if ev ();

    edge_sync u_edge (
        .clk    (clk),
        .rst    (rst),
        .pin_in (demod_in),
        .ev     (ev.src)
    );

    logic [7:0]  bank_ptr_q, bank_ptr_d;
    logic [7:0]  wide_ctrl_q, wide_ctrl_d;
    logic [7:0]  hold_lo_q, hold_lo_d;
    logic [7:0]  hold_hi_q, hold_hi_d;
    logic [7:0]  wcap_lo_q, wcap_lo_d;
    logic [7:0]  wcap_hi_q, wcap_hi_d;
    logic [7:0]  ncap_lo_q, ncap_lo_d;
    logic [7:0]  ncap_hi_q, ncap_hi_d;
    logic        sync_q, sync_d;
    logic        narrow_run_q, narrow_run_d;
    logic [7:0]  narrow_cnt_q, narrow_cnt_d;
    wide_state_t wstate_q, wstate_d;
    logic [15:0] wide_cnt_q, wide_cnt_d;
    logic [7:0]  div_q, div_d;
    logic        wave_q, wave_d;
    logic        irq_cap_q, irq_cap_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        hit_q, hit_d;

    logic        bank_sel;
    logic [3:0]  ofs;
    logic        wr_bank, rd_bank;
    logic        wide_tick, wide_run, wide_edge, cap_event, timeout_event;

    // Bank D only appears in the low sixteen addresses
    always_comb
    begin
        ofs      = reg_addr[3:0];
        bank_sel = (bank_ptr_q[3:0] == BANK_CTRL_D) && (reg_addr[7:4] == LOW_GROUP);
        wr_bank  = reg_wr & bank_sel;
        rd_bank  = reg_rd & bank_sel;
    end

    assign wide_run  = (wstate_q != WS_STOP);
    assign wide_tick = wide_ctrl_q[WC_RATE_BIT] ? (div_q == 8'(RATE_DIV - 1)) : 1'b1;
    assign wide_edge = ev.rise | ev.fall;
    assign timeout_event = wide_run & wide_tick & (wide_cnt_q == 16'h0000);
    assign cap_event = (wstate_q == WS_RUN) & wide_ctrl_q[WC_DEMOD_BIT] & wide_edge;

    always_comb
    begin
        bank_ptr_d   = bank_ptr_q;
        wide_ctrl_d  = wide_ctrl_q;
        hold_lo_d    = hold_lo_q;
        hold_hi_d    = hold_hi_q;
        wcap_lo_d    = wcap_lo_q;
        wcap_hi_d    = wcap_hi_q;
        ncap_lo_d    = ncap_lo_q;
        ncap_hi_d    = ncap_hi_q;
        sync_d       = sync_q;
        narrow_run_d = narrow_run_q;
        narrow_cnt_d = narrow_cnt_q;
        wstate_d     = wstate_q;
        wide_cnt_d   = wide_cnt_q;
        wave_d       = wave_q;
        div_d        = (div_q == 8'(RATE_DIV - 1)) ? 8'h00 : div_q + 8'h01;

        // Narrow counter measures each phase of the input
        if (narrow_run_q)
        begin
            if (ev.fall)
            begin
                ncap_hi_d    = narrow_cnt_q;
                narrow_cnt_d = 8'h00;
            end
            else if (ev.rise)
            begin
                ncap_lo_d    = narrow_cnt_q;
                narrow_cnt_d = 8'h00;
            end
            else if (narrow_cnt_q != NARROW_MAX)
            begin
                narrow_cnt_d = narrow_cnt_q + 8'h01;
            end
        end

        // Wide counter counts down and reloads from the hold pair
        if (cap_event)
        begin
            wcap_hi_d  = wide_cnt_q[15:8];
            wcap_lo_d  = wide_cnt_q[7:0];
            wide_cnt_d = {hold_hi_q, hold_lo_q};
            if (wide_ctrl_q[WC_EDGE_ONCE_BIT])
            begin
                wstate_d = WS_HELD;
            end
        end
        else if (timeout_event)
        begin
            wide_cnt_d = {hold_hi_q, hold_lo_q};
            wave_d     = ~wave_q;
        end
        else if (wide_run && wide_tick)
        begin
            wide_cnt_d = wide_cnt_q - 16'h0001;
        end

        // Set wins over a write-one clear in the same cycle
        wide_ctrl_d[WC_TIMEOUT_BIT] = timeout_event | (wide_ctrl_q[WC_TIMEOUT_BIT]
            & ~(wr_bank && ofs == WIDE_CTRL_OFS && reg_wdata[WC_TIMEOUT_BIT]));

        if (reg_wr && reg_addr == BANK_PTR_ADDR)
        begin
            bank_ptr_d = reg_wdata;
        end

        if (wr_bank)
        begin
            case (ofs)
                WIDE_CTRL_OFS:
                begin
                    wide_ctrl_d = {reg_wdata[7:WC_TIMEOUT_BIT + 1],
                                   wide_ctrl_d[WC_TIMEOUT_BIT],
                                   reg_wdata[WC_TIMEOUT_BIT - 1:0]};
                end
                SHARED_CTRL_OFS:
                begin
                    sync_d = reg_wdata[SH_SYNC_BIT];
                    if (reg_wdata[SH_SYNC_BIT])
                    begin
                        // Either run bit starts both so they leave reset together
                        narrow_run_d = reg_wdata[SH_WIDE_RUN_BIT] | reg_wdata[SH_NARROW_RUN_BIT];
                        wstate_d     = narrow_run_d ? WS_RUN : WS_STOP;
                    end
                    else
                    begin
                        narrow_run_d = reg_wdata[SH_NARROW_RUN_BIT];
                        wstate_d     = reg_wdata[SH_WIDE_RUN_BIT] ? WS_RUN : WS_STOP;
                    end
                    if (narrow_run_d && !narrow_run_q)
                    begin
                        narrow_cnt_d = 8'h00;
                    end
                    if (wstate_d == WS_RUN && !wide_run)
                    begin
                        wide_cnt_d = {hold_hi_q, hold_lo_q};
                    end
                end
                WIDE_HOLD_LOWER_OFS: hold_lo_d = reg_wdata;
                WIDE_HOLD_UPPER_OFS: hold_hi_d = reg_wdata;
                default:
                begin
                    // Capture registers ignore software writes
                    wcap_lo_d = wcap_lo_d;
                end
            endcase
        end
    end

    // Read data registered one cycle after the strobe
    always_comb
    begin
        rdata_d = 8'h00;
        hit_d   = 1'b0;
        if (reg_rd && reg_addr == BANK_PTR_ADDR)
        begin
            rdata_d = bank_ptr_q;
            hit_d   = 1'b1;
        end
        else if (rd_bank)
        begin
            hit_d = 1'b1;
            case (ofs)
                WIDE_CTRL_OFS:       rdata_d = wide_ctrl_q;
                SHARED_CTRL_OFS:     rdata_d = {wide_run, narrow_run_q, sync_q, 5'b0_0000};
                WIDE_HOLD_LOWER_OFS: rdata_d = hold_lo_q;
                WIDE_HOLD_UPPER_OFS: rdata_d = hold_hi_q;
                WIDE_CAP_LOWER_OFS:  rdata_d = wcap_lo_q;
                WIDE_CAP_UPPER_OFS:  rdata_d = wcap_hi_q;
                NARROW_CAP_LOW_OFS:  rdata_d = ncap_lo_q;
                NARROW_CAP_HIGH_OFS: rdata_d = ncap_hi_q;
                default:             rdata_d = 8'h00;
            endcase
        end
        irq_cap_d = cap_event & wide_ctrl_q[WC_CAP_MASK_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bank_ptr_q   <= BANK_PTR_RESET;
            wide_ctrl_q  <= WIDE_CTRL_RESET;
            hold_lo_q    <= HOLD_RESET;
            hold_hi_q    <= HOLD_RESET;
            wcap_lo_q    <= CAPTURE_RESET;
            wcap_hi_q    <= CAPTURE_RESET;
            ncap_lo_q    <= CAPTURE_RESET;
            ncap_hi_q    <= CAPTURE_RESET;
            sync_q       <= 1'b0;
            narrow_run_q <= 1'b0;
            narrow_cnt_q <= 8'h00;
            wstate_q     <= WS_STOP;
            wide_cnt_q   <= 16'h0000;
            div_q        <= 8'h00;
            wave_q       <= 1'b0;
            irq_cap_q    <= 1'b0;
            rdata_q      <= 8'h00;
            hit_q        <= 1'b0;
        end
        else
        begin
            bank_ptr_q   <= bank_ptr_d;
            wide_ctrl_q  <= wide_ctrl_d;
            hold_lo_q    <= hold_lo_d;
            hold_hi_q    <= hold_hi_d;
            wcap_lo_q    <= wcap_lo_d;
            wcap_hi_q    <= wcap_hi_d;
            ncap_lo_q    <= ncap_lo_d;
            ncap_hi_q    <= ncap_hi_d;
            sync_q       <= sync_d;
            narrow_run_q <= narrow_run_d;
            narrow_cnt_q <= narrow_cnt_d;
            wstate_q     <= wstate_d;
            wide_cnt_q   <= wide_cnt_d;
            div_q        <= div_d;
            wave_q       <= wave_d;
            irq_cap_q    <= irq_cap_d;
            rdata_q      <= rdata_d;
            hit_q        <= hit_d;
        end
    end

    assign reg_rdata   = rdata_q;
    assign reg_hit     = hit_q;
    assign bank_group  = bank_ptr_q[7:4];
    assign irq_capture = irq_cap_q;
    assign irq_timeout = wide_ctrl_q[WC_TIMEOUT_BIT] & wide_ctrl_q[WC_CNT_MASK_BIT];
    assign pin_out     = wide_ctrl_q[WC_PIN_SEL_BIT] ? wave_q : gpo_value;

    a_narrow_high_cap: assert property (@(posedge clk) disable iff (rst)
        narrow_run_q && ev.fall |=> ncap_hi_q == $past(narrow_cnt_q))
        else $error("narrow high phase not captured");

    a_narrow_low_cap: assert property (@(posedge clk) disable iff (rst)
        narrow_run_q && ev.rise |=> ncap_lo_q == $past(narrow_cnt_q))
        else $error("narrow low phase not captured");

    a_wide_pair_same: assert property (@(posedge clk) disable iff (rst)
        cap_event |=> {wcap_hi_q, wcap_lo_q} == $past(wide_cnt_q))
        else $error("wide capture bytes inconsistent");

    a_cap_write_ignored: assert property (@(posedge clk) disable iff (rst)
        wr_bank && ofs == WIDE_CAP_UPPER_OFS && !cap_event |=> $stable(wcap_hi_q))
        else $error("capture register changed by write");

    a_once_ignores_edges: assert property (@(posedge clk) disable iff (rst)
        wstate_q == WS_HELD && wide_edge && !wr_bank |=> $stable(wcap_lo_q) && wstate_q == WS_HELD)
        else $error("edge captured after first in once mode");

    a_timeout_sets: assert property (@(posedge clk) disable iff (rst)
        timeout_event |=> wide_ctrl_q[WC_TIMEOUT_BIT] ##1 1'b1)
        else $error("timeout flag not set");

    a_capture_irq: assert property (@(posedge clk) disable iff (rst)
        cap_event && wide_ctrl_q[WC_CAP_MASK_BIT] |=> irq_capture)
        else $error("capture interrupt missing");

    a_sync_both_run: assert property (@(posedge clk) disable iff (rst)
        wr_bank && ofs == SHARED_CTRL_OFS && reg_wdata[SH_SYNC_BIT]
        |=> wide_run == narrow_run_q)
        else $error("synchronised counters disagree");

    a_run_readback: assert property (@(posedge clk) disable iff (rst)
        rd_bank && ofs == SHARED_CTRL_OFS |=> reg_rdata[SH_WIDE_RUN_BIT] == $past(wide_run))
        else $error("run bit readback wrong");

    a_normal_bank_miss: assert property (@(posedge clk) disable iff (rst)
        reg_rd && bank_ptr_q[3:0] == BANK_NORMAL && reg_addr[7:4] == LOW_GROUP |=> !reg_hit)
        else $error("bank registers visible in normal file");

endmodule : dual_counter_capture_regs

// >>> testbench/dual_counter_capture_regs_bench.sv
// Self-checking bench for the counter capture register block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dual_counter_capture_regs_bench;
    import counter_regs_pkg::*;
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       demod_in  = 1'b0;
    logic       gpo_value = 1'b0;
    logic [7:0] reg_rdata;
    logic       reg_hit;
    logic [3:0] bank_group;
    logic       pin_out;
    logic       irq_capture;
    logic       irq_timeout;
    int         errors    = 0;
    int         n_tests   = 0;
    int         caps      = 0;

    dual_counter_capture_regs #(.RATE_DIV(2)) uut (
        .clk         (clk),
        .rst         (rst),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .reg_hit     (reg_hit),
        .bank_group  (bank_group),
        .demod_in    (demod_in),
        .gpo_value   (gpo_value),
        .pin_out     (pin_out),
        .irq_capture (irq_capture),
        .irq_timeout (irq_timeout)
    );

    always #10 clk = ~clk;

    // Capture pulses stand one cycle; count them mid-cycle, away from the launch edge
    always @(negedge clk)
        if (irq_capture === 1'b1)
            caps++;

    task automatic tally_and_finish;
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
        h        = reg_hit;
    endtask : rd

    task automatic pin_phase(input logic v, input int n);
        @(negedge clk);
        demod_in = v;
        repeat (n) @(negedge clk);
    endtask : pin_phase

    // Reads mid-phase; phase length stays n+1 cycles whatever is read
    task automatic phase_read(input logic v, input int n, input logic [7:0] a,
                              output logic [7:0] d);
        logic h;
        @(negedge clk);
        demod_in = v;
        repeat (6) @(negedge clk);
        rd(a, d, h);
        repeat (n - 8) @(negedge clk);
    endtask : phase_read

    task automatic t_bank;
        logic [7:0] d;
        logic       h;
        rd(BANK_PTR_ADDR, d, h);
        `CHK("pointer reset", BANK_PTR_RESET, d)
        `CHK("group reset", 4'h0, bank_group)
        rd(8'h03, d, h);
        `CHK("normal file hit", 1'b0, h)
        wr(BANK_PTR_ADDR, 8'h0f);
        rd(8'h03, d, h);
        `CHK("bank f hit", 1'b0, h)
        wr(BANK_PTR_ADDR, 8'h5d);
        `CHK("group", 4'h5, bank_group)
        rd(8'h03, d, h);
        `CHK("shared hit", 1'b1, h)
        `CHK("shared reset", 8'h00, d & 8'he0)
        rd(8'h0c, d, h);
        `CHK("unmapped hit", 1'b1, h)
        `CHK("unmapped data", 8'h00, d)
    endtask : t_bank

    task automatic t_regs;
        logic [7:0] d;
        logic       h;
        wr(8'h03, 8'he0);
        rd(8'h03, d, h);
        `CHK("shared set", 8'he0, d & 8'he0)
        wr(8'h03, 8'h00);
        rd(8'h03, d, h);
        `CHK("shared clear", 8'h00, d & 8'he0)
        rd(8'h07, d, h);
        `CHK("hold reset", HOLD_RESET, d)
        wr(8'h07, 8'ha5);
        rd(8'h07, d, h);
        `CHK("hold rw", 8'ha5, d)
        for (int a = 8; a < 12; a++)
        begin
            wr(8'(a), 8'h5a);
            rd(8'(a), d, h);
            `CHK("capture ro", CAPTURE_RESET, d)
        end
    endtask : t_regs

    task automatic t_narrow;
        logic [7:0] x;
        logic [7:0] hi1;
        logic [7:0] hi2;
        logic [7:0] lo1;
        logic [7:0] lo2;
        wr(8'h03, 8'h40);
        phase_read(1'b1, 30, 8'h0a, x);
        phase_read(1'b0, 40, 8'h0b, hi1);
        phase_read(1'b1, 35, 8'h0a, lo1);
        phase_read(1'b0, 45, 8'h0b, hi2);
        phase_read(1'b1, 20, 8'h0a, lo2);
        `CHK("high phase step", 8'h05, 8'(hi2 - hi1))
        `CHK("low phase step", 8'h05, 8'(lo2 - lo1))
        wr(8'h03, 8'h00);
    endtask : t_narrow

    task automatic t_wide_demod;
        logic [7:0] lo;
        logic [7:0] hi;
        logic       h;
        int         c0;
        wr(8'h06, 8'h34);
        wr(8'h07, 8'h12);
        wr(8'h02, 8'h44);
        wr(8'h03, 8'h80);
        c0 = caps;
        pin_phase(1'b0, 20);
        pin_phase(1'b1, 20);
        `CHK("every edge", 2, caps - c0)
        rd(8'h08, lo, h);
        rd(8'h09, hi, h);
        // Reloaded at the first edge, so the second capture sits just below hold
        `CHK("capture pair", 1'b1, ({hi, lo} <= 16'h1234 && {hi, lo} > 16'h120c))
        wr(8'h02, 8'h64);
        wr(8'h03, 8'h00);
        wr(8'h03, 8'h80);
        c0 = caps;
        pin_phase(1'b0, 20);
        pin_phase(1'b1, 20);
        pin_phase(1'b0, 20);
        `CHK("first edge only", 1, caps - c0)
        wr(8'h02, 8'h40);
        // Leave the held state so edges are captured again, with the capture interrupt masked
        wr(8'h03, 8'h80);
        c0 = caps;
        pin_phase(1'b1, 20);
        pin_phase(1'b0, 20);
        `CHK("capture masked", 0, caps - c0)
        wr(8'h03, 8'h00);
    endtask : t_wide_demod

    task automatic t_timeout;
        logic [7:0] d;
        logic       h;
        // Earlier runs leave the flag set; clear it so the irq proves a new timeout
        wr(8'h02, 8'h10);
        wr(8'h06, 8'h10);
        wr(8'h07, 8'h00);
        wr(8'h02, 8'h02);
        wr(8'h03, 8'h80);
        `CHK("timeout early", 1'b0, irq_timeout)
        for (int i = 0; i < 100 && irq_timeout !== 1'b1; i++)
            @(negedge clk);
        `CHK("timeout irq", 1'b1, irq_timeout)
        wr(8'h02, 8'h00);
        `CHK("timeout masked", 1'b0, irq_timeout)
        rd(8'h02, d, h);
        `CHK("flag kept", 1'b1, d[WC_TIMEOUT_BIT])
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h10);
        rd(8'h02, d, h);
        `CHK("flag cleared", 1'b0, d[WC_TIMEOUT_BIT])
    endtask : t_timeout

    task automatic t_pin;
        int changes;
        logic last;
        changes = 0;
        wr(8'h02, 8'h00);
        gpo_value = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("pin gpo high", 1'b1, pin_out)
        gpo_value = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("pin gpo low", 1'b0, pin_out)
        wr(8'h02, 8'h01);
        wr(8'h03, 8'h80);
        last = pin_out;
        repeat (80)
        begin
            @(negedge clk);
            if (pin_out !== last)
                changes++;
            last = pin_out;
        end
        `CHK("pin waveform", 1'b1, changes > 1)
        wr(8'h03, 8'h00);
    endtask : t_pin

    initial
    begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        `CHK("pin after reset", gpo_value, pin_out)
        t_bank();
        t_regs();
        t_narrow();
        t_wide_demod();
        t_timeout();
        t_pin();
        tally_and_finish();
    end

    // About 530 cycles are needed; cut off well beyond that
    initial
    begin
        #400000;
        errors++;
        tally_and_finish();
    end
endmodule : dual_counter_capture_regs_bench
